/* hdl/pcq_top.sv */
// Endpoint configuration-space quirks: capability chain, reset values, ECRC, FLR, loopback
//
// What this block does
// - Virtual Channel capability always present whenever Secondary PCIe capability is.
// - TC/VC map of VC0 resource control resets to 8'h01.
// - Gen3 loopback slave leaves Loopback.Active only on a training reset.
// - No Power Budgeting capability exists in the chain.
// - Resizable BAR only switched on at run time after configuration done.
// - Processing-hints completer support is never advertised.
// - D1 reported unsupported and never entered.
// - Port type is always endpoint; root port cannot be chosen.
// - Header log overflow status reads zero in virtual-function space.
// - Reset of a function carrying SR-IOV is refused as unsupported.
// - Function reset of function 0 clears its ARI capable hierarchy bit.
`timescale 1ns/10ps
`default_nettype none
`include "pcq_map.svh"
module pcq_top
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sec_pcie_en,
  input wire logic vc_cap_en,
  input wire logic sriov_en,
  input wire logic pf1_en,
  input wire logic cfg_done_pin,
  input wire logic lb_enter_pin,
  input wire logic lb_exit_pin,
  input wire logic gen3_pin,
  input wire logic ltssm_rst,
  input wire logic rbar_arm,
  input wire logic flr_req,
  input wire logic flr_func,
  input wire logic hlo_event,
  input wire logic cfg_rd_en,
  input wire pcq_pkg::pcq_func_e cfg_rd_func,
  input wire logic [9:0] cfg_rd_addr,
  input wire logic cfg_wr_en,
  input wire pcq_pkg::pcq_func_e cfg_wr_func,
  input wire logic [9:0] cfg_wr_addr,
  input wire logic [31:0] cfg_wr_data,
  output logic [31:0] cfg_rd_data,
  output logic cfg_rd_valid,
  output logic in_loopback,
  output logic [1:0] ecrc_gen_en,
  output logic [1:0] ecrc_chk_en,
  output logic [1:0] pm_state,
  output logic ari_hier,
  output logic flr_refused,
  output logic rbar_on,
  output logic [7:0] tcvc_map
);
  import pcq_pkg::*;
  function automatic pcq_slot_e pcq_slot(input logic [9:0] a);
    case (a)
      `PCQ_OFF_PM_HDR: pcq_slot = PCQ_S_PM_HDR;
      `PCQ_OFF_PMCSR: pcq_slot = PCQ_S_PMCSR;
      `PCQ_OFF_PCIE_HDR: pcq_slot = PCQ_S_PCIE_HDR;
      `PCQ_OFF_DEVCAP: pcq_slot = PCQ_S_DEVCAP;
      `PCQ_OFF_DEVCAP2: pcq_slot = PCQ_S_DEVCAP2;
      `PCQ_OFF_AER_HDR: pcq_slot = PCQ_S_AER_HDR;
      `PCQ_OFF_AER_CORR: pcq_slot = PCQ_S_AER_CORR;
      `PCQ_OFF_AER_CTL: pcq_slot = PCQ_S_AER_CTL;
      `PCQ_OFF_VC_HDR: pcq_slot = PCQ_S_VC_HDR;
      `PCQ_OFF_VC_RES: pcq_slot = PCQ_S_VC_RES;
      `PCQ_OFF_SEC_HDR: pcq_slot = PCQ_S_SEC_HDR;
      `PCQ_OFF_SRIOV_HDR: pcq_slot = PCQ_S_SRIOV_HDR;
      `PCQ_OFF_SRIOV_CTL: pcq_slot = PCQ_S_SRIOV_CTL;
      `PCQ_OFF_RBAR_HDR: pcq_slot = PCQ_S_RBAR_HDR;
      default: pcq_slot = PCQ_S_NONE;
    endcase
  endfunction
  function automatic logic [11:0] pcq_ext_off(input int j);
    case (j)
      0: pcq_ext_off = `PCQ_BYTE_AER;
      1: pcq_ext_off = `PCQ_BYTE_VC;
      2: pcq_ext_off = `PCQ_BYTE_SEC;
      3: pcq_ext_off = `PCQ_BYTE_SRIOV;
      default: pcq_ext_off = `PCQ_BYTE_RBAR;
    endcase
  endfunction
  // Next pointer skips every absent capability; power budgeting has no entry at all
  function automatic logic [11:0] pcq_next(input logic [4:0] pres, input int from);
    pcq_next = 12'h000;
    for (int j = 4; j >= 0; j--)
    begin
      if (j > from && pres[j])
        pcq_next = pcq_ext_off(j);
    end
  endfunction
  // Pin inputs pass two flip-flops before use
  localparam int NSYNC = 4;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  wire [NSYNC-1:0] pins = {gen3_pin, lb_exit_pin, lb_enter_pin, cfg_done_pin};
  genvar g;
  generate
    for (g = 0; g < NSYNC; g++)
    begin : g_sync
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
          {sync_b[g], sync_a[g]} <= 2'b00;
        else
          {sync_b[g], sync_a[g]} <= {sync_a[g], pins[g]};
      end
    end
  endgenerate
  wire cfg_done_s = sync_b[0];
  pcq_lb_fsm u_lb (
    .clk(clk),
    .arst_n(arst_n),
    .lb_enter(sync_b[1]),
    .lb_exit(sync_b[2]),
    .gen3(sync_b[3]),
    .ltssm_rst(ltssm_rst),
    .in_loopback(in_loopback)
  );
  // Capability presence: aer, vc, sec, sriov, rbar
  wire vc_pres = vc_cap_en | sec_pcie_en;
  wire [4:0] cap_pres = {rbar_on, sriov_en, sec_pcie_en, vc_pres, 1'b1};
  // Read pipeline: slot and ROM word in stage one, merged word in stage two
  pcq_slot_e rd_slot_c;
  pcq_slot_e rd_slot_q;
  pcq_func_e rd_func_q;
  logic rd_v1;
  logic [31:0] rom_q;
  assign rd_slot_c = pcq_slot(cfg_rd_addr);

  pcq_cfg_rom #(
    .WIDTH(32)
  ) u_rom (
    .clk(clk),
    .arst_n(arst_n),
    .slot(rd_slot_c),
    .rdata(rom_q)
  );

  wire rd_pf1 = (rd_func_q == PCQ_F_PF1);
  wire rd_vf = (rd_func_q == PCQ_F_VF);
  logic hlo_sts;
  logic [1:0] pm_st1;
  wire [1:0] rd_pm = rd_pf1 ? pm_st1 : pm_state;
  wire rd_gen = rd_pf1 ? ecrc_gen_en[1] : ecrc_gen_en[0];
  wire rd_chk = rd_pf1 ? ecrc_chk_en[1] : ecrc_chk_en[0];
  wire rd_hlo = hlo_sts & ~rd_vf;

  logic [31:0] dyn;
  logic slot_hidden;
  always_comb
  begin
    dyn = 32'h0000_0000;
    slot_hidden = 1'b0;
    case (rd_slot_q)
      PCQ_S_PMCSR: dyn[1:0] = rd_pm;
      PCQ_S_AER_HDR: dyn[31:20] = pcq_next(cap_pres, 0);
      PCQ_S_AER_CORR: dyn[`PCQ_HLO_BIT] = rd_hlo;
      PCQ_S_AER_CTL:
      begin
        dyn[`PCQ_ECRC_GEN_BIT] = rd_gen;
        dyn[`PCQ_ECRC_CHK_BIT] = rd_chk;
      end
      PCQ_S_VC_HDR:
      begin
        dyn[31:20] = pcq_next(cap_pres, 1);
        slot_hidden = ~cap_pres[1];
      end
      PCQ_S_VC_RES:
      begin
        dyn[7:0] = tcvc_map;
        slot_hidden = ~cap_pres[1];
      end
      PCQ_S_SEC_HDR:
      begin
        dyn[31:20] = pcq_next(cap_pres, 2);
        slot_hidden = ~cap_pres[2];
      end
      PCQ_S_SRIOV_HDR:
      begin
        dyn[31:20] = pcq_next(cap_pres, 3);
        slot_hidden = ~cap_pres[3];
      end
      PCQ_S_SRIOV_CTL:
      begin
        dyn[`PCQ_ARI_BIT] = ari_hier & ~rd_pf1;
        slot_hidden = ~cap_pres[3];
      end
      PCQ_S_RBAR_HDR: slot_hidden = ~cap_pres[4];
      default: dyn = 32'h0000_0000;
    endcase
  end
  wire [31:0] next_rd_data = slot_hidden ? 32'h0000_0000 : (rom_q | dyn);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_slot_q <= PCQ_S_NONE;
      rd_func_q <= PCQ_F_PF0;
      rd_v1 <= 1'b0;
      cfg_rd_valid <= 1'b0;
      cfg_rd_data <= 32'h0000_0000;
    end
    else
    begin
      rd_slot_q <= rd_slot_c;
      rd_func_q <= cfg_rd_func;
      rd_v1 <= cfg_rd_en;
      cfg_rd_valid <= rd_v1;
      cfg_rd_data <= rd_v1 ? next_rd_data : 32'h0000_0000;
    end
  end
  // Write decode
  wire wr_slot_ok = cfg_wr_en && (cfg_wr_func != PCQ_F_VF);
  wire [3:0] wr_slot = pcq_slot(cfg_wr_addr);
  wire wr_pf1 = (cfg_wr_func == PCQ_F_PF1);
  wire wr_pm = wr_slot_ok && (wr_slot == PCQ_S_PMCSR);
  wire wr_d1 = (cfg_wr_data[1:0] == `PCQ_PM_D1);
  wire wr_ecrc = wr_slot_ok && (wr_slot == PCQ_S_AER_CTL) && (!wr_pf1 || pf1_en);
  wire wr_corr = wr_slot_ok && (wr_slot == PCQ_S_AER_CORR) && !wr_pf1;
  wire wr_vc = wr_slot_ok && (wr_slot == PCQ_S_VC_RES) && vc_pres;
  wire wr_ari = wr_slot_ok && (wr_slot == PCQ_S_SRIOV_CTL) && !wr_pf1 && sriov_en;
  wire flr_pf0 = flr_req && !flr_func;
  wire flr_pf1 = flr_req && flr_func && pf1_en;
  wire flr_bad = flr_pf0 && sriov_en;

  // With two functions a write to either one sets both, so they agree after every write
  wire [1:0] ecrc_sel = pf1_en ? 2'b11 : 2'b01;
  wire [1:0] next_gen = wr_ecrc ? ((ecrc_gen_en & ~ecrc_sel) |
    (ecrc_sel & {2{cfg_wr_data[`PCQ_ECRC_GEN_BIT]}})) : ecrc_gen_en;
  wire [1:0] next_chk = wr_ecrc ? ((ecrc_chk_en & ~ecrc_sel) |
    (ecrc_sel & {2{cfg_wr_data[`PCQ_ECRC_CHK_BIT]}})) : ecrc_chk_en;
  // Event wins over a same-cycle clear of the overflow flag
  wire next_hlo = hlo_event | (hlo_sts & ~(wr_corr & cfg_wr_data[`PCQ_HLO_BIT]));

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ecrc_gen_en <= 2'b00;
      ecrc_chk_en <= 2'b00;
      hlo_sts <= 1'b0;
      tcvc_map <= `PCQ_TCVC_RST;
      rbar_on <= 1'b0;
      flr_refused <= 1'b0;
    end
    else
    begin
      ecrc_gen_en <= next_gen;
      ecrc_chk_en <= next_chk;
      hlo_sts <= next_hlo;
      if (wr_vc)
        tcvc_map <= cfg_wr_data[7:0];
      if (rbar_arm && cfg_done_s)
        rbar_on <= 1'b1;
      flr_refused <= flr_bad;
    end
  end
  // A refused reset still clears ARI; other function state is left untouched
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pm_state <= `PCQ_PM_D0;
      pm_st1 <= `PCQ_PM_D0;
      ari_hier <= 1'b0;
    end
    else
    begin
      if (flr_pf0)
        ari_hier <= 1'b0;
      else if (wr_ari)
        ari_hier <= cfg_wr_data[`PCQ_ARI_BIT];
      if (flr_pf0 && !sriov_en)
        pm_state <= `PCQ_PM_D0;
      else if (wr_pm && !wr_pf1 && !wr_d1)
        pm_state <= cfg_wr_data[1:0];
      if (flr_pf1)
        pm_st1 <= `PCQ_PM_D0;
      else if (wr_pm && wr_pf1 && !wr_d1)
        pm_st1 <= cfg_wr_data[1:0];
    end
  end
  logic after_rst;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      after_rst <= 1'b0;
    else
      after_rst <= 1'b1;
  end

  AST_VC_WITH_SEC: assert property (@(posedge clk) disable iff (!arst_n)
    (cfg_rd_valid && sec_pcie_en && $past(rd_slot_q == PCQ_S_VC_HDR) && $stable(sec_pcie_en))
    |-> (cfg_rd_data[15:0] == 16'h0002))
    else $error("VC capability hidden while secondary capability enabled");
  AST_TCVC_RESET: assert property (@(posedge clk) disable iff (!arst_n)
    !after_rst |-> (tcvc_map == `PCQ_TCVC_RST))
    else $error("TC/VC map reset value wrong");
  AST_LB_GEN3_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
    (in_loopback && sync_b[3] && !ltssm_rst) ##1 (sync_b[3] && !ltssm_rst) |=> in_loopback)
    else $error("Gen3 loopback left without training reset");
  AST_RD_LATENCY: assert property (@(posedge clk) disable iff (!arst_n)
    cfg_rd_en |-> ##2 cfg_rd_valid)
    else $error("Read answer not two cycles later");
  AST_RBAR_AFTER_CFG: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(rbar_on) |-> $past(cfg_done_s && rbar_arm))
    else $error("Resizable BAR enabled before configuration done");
  AST_ECRC_PAIR: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_ecrc && pf1_en) |=> (ecrc_gen_en[0] == ecrc_gen_en[1]) &&
      (ecrc_chk_en[0] == ecrc_chk_en[1]))
    else $error("ECRC enables differ between functions");
  AST_ECRC_PF0_FREE: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_ecrc && !pf1_en && !wr_pf1) |=>
      (ecrc_gen_en[0] == $past(cfg_wr_data[`PCQ_ECRC_GEN_BIT])))
    else $error("Function 0 ECRC write not taken");
  AST_NO_D1: assert property (@(posedge clk) disable iff (!arst_n)
    (pm_state != `PCQ_PM_D1) && (pm_st1 != `PCQ_PM_D1))
    else $error("D1 state entered");
  AST_VF_HLO: assert property (@(posedge clk) disable iff (!arst_n)
    (rd_v1 && rd_vf && rd_slot_q == PCQ_S_AER_CORR) |=> !cfg_rd_data[`PCQ_HLO_BIT])
    else $error("Header log overflow visible in VF space");
  AST_FLR_REFUSE: assert property (@(posedge clk) disable iff (!arst_n)
    (flr_req && !flr_func && sriov_en) |=> flr_refused ##1 !flr_refused)
    else $error("SR-IOV function reset not flagged");
  AST_FLR_ARI: assert property (@(posedge clk) disable iff (!arst_n)
    (flr_req && !flr_func) |=> !ari_hier)
    else $error("ARI capable hierarchy survived function reset");
  COV_LOOPBACK: cover property (@(posedge clk) disable iff (!arst_n)
    in_loopback ##[1:20] !in_loopback);
  COV_FLR: cover property (@(posedge clk) disable iff (!arst_n) flr_refused);
  COV_RBAR: cover property (@(posedge clk) disable iff (!arst_n) $rose(rbar_on));
  COV_ECRC2: cover property (@(posedge clk) disable iff (!arst_n) pf1_en && ecrc_gen_en == 2'b11);
endmodule
`default_nettype wire

/* hdl/pcq_map.svh */
// Offsets, field positions, reset values and constant words of the endpoint configuration space
`ifndef PCQ_MAP_SVH
`define PCQ_MAP_SVH
`define PCQ_TCVC_RST 8'h01
`define PCQ_ARI_BIT 4
`define PCQ_HLO_BIT 15
`define PCQ_ECRC_GEN_BIT 6
`define PCQ_ECRC_CHK_BIT 8
`define PCQ_PM_D0 2'h0
`define PCQ_PM_D1 2'h1
`define PCQ_OFF_PM_HDR 10'h010
`define PCQ_OFF_PMCSR 10'h011
`define PCQ_OFF_PCIE_HDR 10'h018
`define PCQ_OFF_DEVCAP 10'h019
`define PCQ_OFF_DEVCAP2 10'h021
`define PCQ_OFF_AER_HDR 10'h040
`define PCQ_OFF_AER_CORR 10'h044
`define PCQ_OFF_AER_CTL 10'h046
`define PCQ_OFF_VC_HDR 10'h050
`define PCQ_OFF_VC_RES 10'h055
`define PCQ_OFF_SEC_HDR 10'h060
`define PCQ_OFF_SRIOV_HDR 10'h070
`define PCQ_OFF_SRIOV_CTL 10'h072
`define PCQ_OFF_RBAR_HDR 10'h080
`define PCQ_BYTE_AER 12'h100
`define PCQ_BYTE_VC 12'h140
`define PCQ_BYTE_SEC 12'h180
`define PCQ_BYTE_SRIOV 12'h1C0
`define PCQ_BYTE_RBAR 12'h200
`define PCQ_ROM_PM_HDR 32'h0003_6001
`define PCQ_ROM_PCIE_HDR 32'h0002_0010
`define PCQ_ROM_DEVCAP 32'h0000_8000
`define PCQ_ROM_DEVCAP2 32'h0000_0000
`define PCQ_ROM_AER_HDR 32'h0002_0001
`define PCQ_ROM_AER_CTL 32'h0000_00A0
`define PCQ_ROM_VC_HDR 32'h0001_0002
`define PCQ_ROM_VC_RES 32'h8000_0000
`define PCQ_ROM_SEC_HDR 32'h0001_0019
`define PCQ_ROM_SRIOV_HDR 32'h0001_0010
`define PCQ_ROM_RBAR_HDR 32'h0001_0015
`endif

/* hdl/pcq_pkg.sv */
// Types shared by the configuration-space quirk block
package pcq_pkg;
  typedef enum logic [1:0] {
    PCQ_F_PF0 = 2'b00,
    PCQ_F_PF1 = 2'b01,
    PCQ_F_VF = 2'b10
  } pcq_func_e;
  typedef enum logic [3:0] {
    PCQ_S_NONE = 4'h0,
    PCQ_S_PM_HDR = 4'h1,
    PCQ_S_PMCSR = 4'h2,
    PCQ_S_PCIE_HDR = 4'h3,
    PCQ_S_DEVCAP = 4'h4,
    PCQ_S_DEVCAP2 = 4'h5,
    PCQ_S_AER_HDR = 4'h6,
    PCQ_S_AER_CORR = 4'h7,
    PCQ_S_AER_CTL = 4'h8,
    PCQ_S_VC_HDR = 4'h9,
    PCQ_S_VC_RES = 4'hA,
    PCQ_S_SEC_HDR = 4'hB,
    PCQ_S_SRIOV_HDR = 4'hC,
    PCQ_S_SRIOV_CTL = 4'hD,
    PCQ_S_RBAR_HDR = 4'hE
  } pcq_slot_e;
  typedef enum logic [1:0] {
    PCQ_LB_IDLE = 2'b00,
    PCQ_LB_ACTIVE = 2'b01,
    PCQ_LB_EXIT = 2'b10
  } pcq_lb_e;
endpackage

/* hdl/pcq_cfg_rom.sv */
// Constant words of the configuration space, registered read
`timescale 1ns/10ps
`default_nettype none
`include "pcq_map.svh"
module pcq_cfg_rom
#(
  parameter int WIDTH = 32
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire pcq_pkg::pcq_slot_e slot,
  output logic [WIDTH-1:0] rdata
);
  import pcq_pkg::*;
  logic [31:0] word;
  // The constant words are 32 bits wide; any other width is refused at elaboration
  if (WIDTH != 32)
  begin : g_width_check
    $error("pcq_cfg_rom supports WIDTH 32 only");
  end
  // Port type stays endpoint, no D1, no processing-hint completer
  always_comb
  begin
    case (slot)
      PCQ_S_PM_HDR: word = `PCQ_ROM_PM_HDR;
      PCQ_S_PCIE_HDR: word = `PCQ_ROM_PCIE_HDR;
      PCQ_S_DEVCAP: word = `PCQ_ROM_DEVCAP;
      PCQ_S_DEVCAP2: word = `PCQ_ROM_DEVCAP2;
      PCQ_S_AER_HDR: word = `PCQ_ROM_AER_HDR;
      PCQ_S_AER_CTL: word = `PCQ_ROM_AER_CTL;
      PCQ_S_VC_HDR: word = `PCQ_ROM_VC_HDR;
      PCQ_S_VC_RES: word = `PCQ_ROM_VC_RES;
      PCQ_S_SEC_HDR: word = `PCQ_ROM_SEC_HDR;
      PCQ_S_SRIOV_HDR: word = `PCQ_ROM_SRIOV_HDR;
      PCQ_S_RBAR_HDR: word = `PCQ_ROM_RBAR_HDR;
      default: word = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata <= '0;
    else
      rdata <= word[WIDTH-1:0];
  end
endmodule
`default_nettype wire

/* hdl/pcq_lb_fsm.sv */
// Loopback slave tracking of the link training state machine
`timescale 1ns/10ps
`default_nettype none
module pcq_lb_fsm
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic lb_enter,
  input wire logic lb_exit,
  input wire logic gen3,
  input wire logic ltssm_rst,
  output logic in_loopback
);
  import pcq_pkg::*;
  pcq_lb_e state;
  pcq_lb_e next_state;
  // At Gen3 the normal exit is lost; only a training reset leaves
  wire exit_ok = ltssm_rst | (lb_exit & ~gen3);
  always_comb
  begin
    case (state)
      PCQ_LB_IDLE: next_state = (lb_enter & ~ltssm_rst) ? PCQ_LB_ACTIVE : PCQ_LB_IDLE;
      PCQ_LB_ACTIVE: next_state = exit_ok ? PCQ_LB_EXIT : PCQ_LB_ACTIVE;
      PCQ_LB_EXIT: next_state = PCQ_LB_IDLE;
      default: next_state = PCQ_LB_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= PCQ_LB_IDLE;
      in_loopback <= 1'b0;
    end
    else
    begin
      state <= next_state;
      in_loopback <= (next_state == PCQ_LB_ACTIVE);
    end
  end
endmodule
`default_nettype wire

/* tb/pcq_rc_model.sv */
// Link partner model: loopback master and link rate as seen at the endpoint pins
`timescale 1ns/10ps
`default_nettype none
module pcq_rc_model
(
  input wire logic clk,
  output logic lb_enter_pin,
  output logic lb_exit_pin,
  output logic gen3_pin
);
  initial
  begin
    lb_enter_pin = 1'b0;
    lb_exit_pin = 1'b0;
    gen3_pin = 1'b0;
  end
  task automatic set_rate(input logic g3);
    @(negedge clk);
    gen3_pin = g3;
  endtask
  // Held as a level long enough to pass the endpoint's two-flop synchroniser
  task automatic enter_lb();
    @(negedge clk);
    lb_exit_pin = 1'b0;
    lb_enter_pin = 1'b1;
    repeat (4) @(negedge clk);
    lb_enter_pin = 1'b0;
  endtask
  // At Gen3 this request alone cannot free the slave
  task automatic exit_lb();
    @(negedge clk);
    lb_exit_pin = 1'b1;
    repeat (4) @(negedge clk);
    lb_exit_pin = 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the configuration-space quirk block
`timescale 1ns/10ps
`default_nettype none
`include "pcq_map.svh"
module tb;
  import pcq_pkg::*;
  logic clk, arst_n, sec_pcie_en, vc_cap_en, sriov_en, pf1_en, cfg_done_pin, ltssm_rst;
  logic rbar_arm, flr_req, flr_func, hlo_event, cfg_rd_en, cfg_wr_en;
  pcq_func_e cfg_rd_func, cfg_wr_func;
  logic [9:0] cfg_rd_addr, cfg_wr_addr;
  logic [31:0] cfg_wr_data, cfg_rd_data, rd;
  wire logic lb_enter_pin, lb_exit_pin, gen3_pin;
  logic cfg_rd_valid, in_loopback, ari_hier, flr_refused, rbar_on;
  logic [1:0] ecrc_gen_en, ecrc_chk_en, pm_state;
  logic [7:0] tcvc_map;
  int failures = 0;
  int checks = 0;
  pcq_top uut (.clk, .arst_n, .sec_pcie_en, .vc_cap_en, .sriov_en, .pf1_en, .cfg_done_pin,
    .lb_enter_pin, .lb_exit_pin, .gen3_pin, .ltssm_rst, .rbar_arm, .flr_req, .flr_func,
    .hlo_event, .cfg_rd_en, .cfg_rd_func, .cfg_rd_addr, .cfg_wr_en, .cfg_wr_func,
    .cfg_wr_addr, .cfg_wr_data, .cfg_rd_data, .cfg_rd_valid, .in_loopback, .ecrc_gen_en,
    .ecrc_chk_en, .pm_state, .ari_hier, .flr_refused, .rbar_on, .tcvc_map);
  pcq_rc_model partner (.clk, .lb_enter_pin, .lb_exit_pin, .gen3_pin);
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cfg_read(input pcq_func_e f, input logic [9:0] a, output logic [31:0] d);
    int n;
    @(negedge clk);
    cfg_rd_en = 1'b1;
    cfg_rd_func = f;
    cfg_rd_addr = a;
    @(negedge clk);
    cfg_rd_en = 1'b0;
    // A missing answer leaves a value no mapped word carries
    d = 32'hDEAD_BEEF;
    for (n = 0; n < 4; n++)
    begin
      @(negedge clk);
      if (cfg_rd_valid === 1'b1)
      begin
        d = cfg_rd_data;
        break;
      end
    end
  endtask
  task automatic rd_chk(input pcq_func_e f, input logic [9:0] a, input logic [31:0] e);
    cfg_read(f, a, rd);
    chk(rd, e);
  endtask
  task automatic cfg_write(input pcq_func_e f, input logic [9:0] a, input logic [31:0] d);
    @(negedge clk);
    cfg_wr_en = 1'b1;
    cfg_wr_func = f;
    cfg_wr_addr = a;
    cfg_wr_data = d;
    @(negedge clk);
    cfg_wr_en = 1'b0;
  endtask
  task automatic flr(input logic f);
    @(negedge clk);
    flr_req = 1'b1;
    flr_func = f;
    @(negedge clk);
    flr_req = 1'b0;
  endtask
  task automatic wait_lb(input logic v);
    int n;
    for (n = 0; n < 12; n++)
    begin
      @(negedge clk);
      if (in_loopback === v)
        break;
    end
  endtask
  function automatic logic [31:0] hdr_rom(input logic [11:0] p);
    case (p)
      `PCQ_BYTE_AER: return `PCQ_ROM_AER_HDR;
      `PCQ_BYTE_VC: return `PCQ_ROM_VC_HDR;
      `PCQ_BYTE_SEC: return `PCQ_ROM_SEC_HDR;
      `PCQ_BYTE_SRIOV: return `PCQ_ROM_SRIOV_HDR;
      `PCQ_BYTE_RBAR: return `PCQ_ROM_RBAR_HDR;
      default: return 32'h0;
    endcase
  endfunction
  // Follows the extended chain; e[0] is the first header, a zero entry ends it
  task automatic walk(input logic [5:0][11:0] e);
    logic [31:0] h;
    int i;
    for (i = 0; i < 5; i++)
    begin
      if (e[i] == 12'h000)
        break;
      h = hdr_rom(e[i]);
      cfg_read(PCQ_F_PF0, e[i][11:2], rd);
      chk(rd, {e[i + 1], h[19:0]});
    end
  endtask
  initial
  begin
    #(25 * 6000);
    failures++;
    print_verdict();
  end
  initial
  begin
    {arst_n, sec_pcie_en, vc_cap_en, sriov_en, pf1_en, cfg_done_pin, ltssm_rst} = 7'h00;
    {rbar_arm, flr_req, flr_func, hlo_event, cfg_rd_en, cfg_wr_en} = 6'h00;
    cfg_rd_func = PCQ_F_PF0;
    cfg_wr_func = PCQ_F_PF0;
    cfg_rd_addr = 10'h000;
    cfg_wr_addr = 10'h000;
    cfg_wr_data = 32'h0;
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    sec_pcie_en = 1'b1;
    @(negedge clk);
    chk(32'(tcvc_map), 32'(`PCQ_TCVC_RST));
    chk(32'({pm_state, in_loopback, rbar_on, ari_hier}), 32'h0);
    rd_chk(PCQ_F_PF0, `PCQ_OFF_VC_RES, 32'h8000_0001);
    rd_chk(PCQ_F_PF0, `PCQ_OFF_PM_HDR, `PCQ_ROM_PM_HDR);
    // D1 support flag of the capabilities word must be clear
    chk(32'(rd[25]), 32'h0);
    rd_chk(PCQ_F_PF0, `PCQ_OFF_PCIE_HDR, `PCQ_ROM_PCIE_HDR);
    // Device/port type field: zero means endpoint
    chk(32'(rd[23:20]), 32'h0);
    rd_chk(PCQ_F_PF0, `PCQ_OFF_DEVCAP2, `PCQ_ROM_DEVCAP2);
    // Processing-hint completer support field must read zero
    chk(32'(rd[13:12]), 32'h0);
    rd_chk(PCQ_F_PF0, `PCQ_OFF_AER_CTL, `PCQ_ROM_AER_CTL);
    rd_chk(PCQ_F_VF, 10'h3FF, 32'h0);
    @(negedge clk);
    rbar_arm = 1'b1;
    @(negedge clk);
    rbar_arm = 1'b0;
    chk(32'(rbar_on), 32'h0);
    cfg_done_pin = 1'b1;
    repeat (3) @(negedge clk);
    rbar_arm = 1'b1;
    @(negedge clk);
    rbar_arm = 1'b0;
    chk(32'(rbar_on), 32'h1);
    walk({12'h000, 12'h000, 12'h200, 12'h180, 12'h140, 12'h100});
    {sec_pcie_en, vc_cap_en, sriov_en} = 3'b001;
    walk({12'h000, 12'h000, 12'h000, 12'h200, 12'h1C0, 12'h100});
    {sec_pcie_en, vc_cap_en, sriov_en} = 3'b010;
    walk({12'h000, 12'h000, 12'h000, 12'h200, 12'h140, 12'h100});
    {sec_pcie_en, vc_cap_en} = 2'b10;
    cfg_write(PCQ_F_PF0, `PCQ_OFF_VC_RES, 32'h0000_007F);
    chk(32'(tcvc_map), 32'h7F);
    rd_chk(PCQ_F_PF0, `PCQ_OFF_VC_RES, 32'h8000_007F);
    sec_pcie_en = 1'b0;
    cfg_write(PCQ_F_PF0, `PCQ_OFF_VC_RES, 32'h0000_0033);
    chk(32'(tcvc_map), 32'h7F);
    cfg_write(PCQ_F_PF0, `PCQ_OFF_AER_CTL, 32'h1 << `PCQ_ECRC_GEN_BIT);
    chk(32'({ecrc_gen_en, ecrc_chk_en}), 32'h4);
    cfg_write(PCQ_F_PF0, `PCQ_OFF_AER_CTL, 32'h1 << `PCQ_ECRC_CHK_BIT);
    chk(32'({ecrc_gen_en, ecrc_chk_en}), 32'h1);
    cfg_write(PCQ_F_PF1, `PCQ_OFF_AER_CTL, 32'h1 << `PCQ_ECRC_GEN_BIT);
    chk(32'({ecrc_gen_en, ecrc_chk_en}), 32'h1);
    pf1_en = 1'b1;
    cfg_write(PCQ_F_PF1, `PCQ_OFF_AER_CTL, 32'h0000_0140);
    chk(32'({ecrc_gen_en, ecrc_chk_en}), 32'hF);
    cfg_write(PCQ_F_PF0, `PCQ_OFF_AER_CTL, 32'h0);
    chk(32'({ecrc_gen_en, ecrc_chk_en}), 32'h0);
    cfg_write(PCQ_F_PF0, `PCQ_OFF_PMCSR, 32'(`PCQ_PM_D1));
    chk(32'(pm_state), 32'h0);
    cfg_write(PCQ_F_PF0, `PCQ_OFF_PMCSR, 32'h3);
    chk(32'(pm_state), 32'h3);
    flr(1'b0);
    chk(32'({flr_refused, pm_state}), 32'h0);
    sriov_en = 1'b1;
    cfg_write(PCQ_F_PF0, `PCQ_OFF_PMCSR, 32'h3);
    cfg_write(PCQ_F_PF0, `PCQ_OFF_SRIOV_CTL, 32'h1 << `PCQ_ARI_BIT);
    chk(32'(ari_hier), 32'h1);
    flr(1'b0);
    chk(32'({flr_refused, pm_state, ari_hier}), 32'hE);
    @(negedge clk);
    hlo_event = 1'b1;
    @(negedge clk);
    hlo_event = 1'b0;
    rd_chk(PCQ_F_PF0, `PCQ_OFF_AER_CORR, 32'h1 << `PCQ_HLO_BIT);
    rd_chk(PCQ_F_VF, `PCQ_OFF_AER_CORR, 32'h0);
    cfg_write(PCQ_F_PF0, `PCQ_OFF_AER_CORR, 32'h1 << `PCQ_HLO_BIT);
    rd_chk(PCQ_F_PF0, `PCQ_OFF_AER_CORR, 32'h0);
    partner.enter_lb();
    wait_lb(1'b1);
    chk(32'(in_loopback), 32'h1);
    partner.exit_lb();
    wait_lb(1'b0);
    chk(32'(in_loopback), 32'h0);
    partner.set_rate(1'b1);
    partner.enter_lb();
    wait_lb(1'b1);
    partner.exit_lb();
    repeat (4) @(negedge clk);
    chk(32'(in_loopback), 32'h1);
    // The bench acts as the controlling logic that must reset training
    ltssm_rst = 1'b1;
    @(negedge clk);
    ltssm_rst = 1'b0;
    chk(32'(in_loopback), 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
